// ===== src/acs_pkg.sv
package acs_pkg;
   // Clock and timing.
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned CONV_V_MAX_NS = 9000;
   localparam int unsigned CONV_T_MAX_NS = 27000;
   localparam int unsigned CONV_V_CYC = CONV_V_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned CONV_T_CYC = CONV_T_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned START_MIN_NS = 20;
   localparam int unsigned START_LOW_CYC =
      (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SCLK_MIN_NS = 40;
   localparam int unsigned SCLK_MIN_CYC =
      (SCLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Half period of the host serial clock, with margin for both synchronisers.
   localparam int unsigned SCLK_HALF_CYC = 12;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned TMR_W = 8;

   // Data widths and channels.
   localparam int unsigned RESULT_W = 10;
   localparam int unsigned THRESH_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned FRAME_W = 16;
   localparam int unsigned N_VIN = 4;
   localparam int unsigned BITS_W = 5;
   localparam logic [ADDR_W-1:0] CH_TEMP = 8'h00;
   localparam logic [ADDR_W-1:0] SEL_THRESH = 8'h0F;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [THRESH_W-1:0] THRESH_RST = 8'hFF;
   localparam logic [BITS_W-1:0] FRAME_SHORT = 5'h08;
   localparam logic [BITS_W-1:0] FRAME_LONG = 5'h10;

   // Positions of the device pin inputs in its synchroniser.
   localparam int unsigned PIN_CONV = 0;
   localparam int unsigned PIN_CS = 1;
   localparam int unsigned PIN_RW = 2;
   localparam int unsigned PIN_SCLK = 3;
   localparam int unsigned PIN_DIN = 4;
   localparam int unsigned N_DEV_PINS = 5;

   // Positions of the host pin inputs in its synchroniser.
   localparam int unsigned HPIN_BUSY = 0;
   localparam int unsigned HPIN_OTF = 1;
   localparam int unsigned HPIN_DOUT = 2;
   localparam int unsigned N_HOST_PINS = 3;
endpackage

// ===== src/acs_if.sv
`timescale 1ns/10ps
`default_nettype none
interface acs_if;
   logic convert_start_n;
   logic busy;
   logic over_temp_flag_n;
   logic cs_n;
   logic rd_wr;
   logic sclk;
   logic din;
   logic dout;
   logic dout_oe;
   logic dout_bus;

   // Data out idles high through a pull-up while nobody drives it.
   assign dout_bus = dout_oe ? dout : 1'b1;

   modport dev (
      input convert_start_n, cs_n, rd_wr, sclk, din,
      output busy, over_temp_flag_n, dout, dout_oe
   );
   modport host (
      output convert_start_n, cs_n, rd_wr, sclk, din,
      input busy, over_temp_flag_n, dout_bus
   );
endinterface
`default_nettype wire

// ===== src/acs_device.sv
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Falling convert start begins 10-bit conversion.
// - Hold on start edge, track after completion.
// - Convert start low at end: power down.
// - Busy high throughout every conversion.
// - Temperature result above threshold drives flag low.
// - Read edge with select low releases flag.
// - Serial port responds only with select low.
// - Data out released on read fall/select rise.
// - Shift out on falling, capture on rising.
// - Host drives read high, write low.
// - Four inputs plus temperature, chosen by address.
// - Voltage conversion completes within 9 us.
// - Temperature conversion completes within 27 us.
module acs_device #(
   parameter int unsigned CONV_V_CYC = acs_pkg::CONV_V_CYC,
   parameter int unsigned CONV_T_CYC = acs_pkg::CONV_T_CYC
) (
   // Link to the host.
   acs_if.dev link,
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Digitised stand-ins for the analog inputs and temperature sensor.
   input wire logic [acs_pkg::N_VIN*acs_pkg::RESULT_W-1:0] analog_inputs,
   input wire logic [acs_pkg::RESULT_W-1:0] temp_code,
   // Converter state.
   output logic track_hold,
   output logic power_down,
   output logic [acs_pkg::RESULT_W-1:0] result
);
   localparam int unsigned RW = acs_pkg::RESULT_W;
   localparam int unsigned NP = acs_pkg::N_DEV_PINS;
   localparam int unsigned CW = acs_pkg::CNT_W;

   initial begin
      if (CONV_V_CYC < 1 || CONV_V_CYC >= (1 << CW) ||
          CONV_T_CYC < 1 || CONV_T_CYC >= (1 << CW)) begin
         $error("acs_device: conversion cycle count out of range");
      end
   end

   typedef enum logic {CV_IDLE, CV_RUN} acs_conv_t;

   // Pin synchroniser: stage 1 feeds stage 2 only, stage 3 finds edges.
   logic [NP-1:0] s1_q, s2_q, s3_q;
   logic [NP-1:0] pins;

   assign pins[acs_pkg::PIN_CONV] = link.convert_start_n;
   assign pins[acs_pkg::PIN_CS] = link.cs_n;
   assign pins[acs_pkg::PIN_RW] = link.rd_wr;
   assign pins[acs_pkg::PIN_SCLK] = link.sclk;
   assign pins[acs_pkg::PIN_DIN] = link.din;

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   logic conv_fall, conv_rise, conv_low;
   logic cs_low, cs_fall, cs_rise;
   logic rw_rise, rw_fall, rw_high;
   logic sclk_rise, sclk_fall, din_s;

   always_comb begin
      conv_low = ~s2_q[acs_pkg::PIN_CONV];
      conv_fall = s3_q[acs_pkg::PIN_CONV] & ~s2_q[acs_pkg::PIN_CONV];
      conv_rise = ~s3_q[acs_pkg::PIN_CONV] & s2_q[acs_pkg::PIN_CONV];
      cs_low = ~s2_q[acs_pkg::PIN_CS];
      cs_fall = s3_q[acs_pkg::PIN_CS] & ~s2_q[acs_pkg::PIN_CS];
      cs_rise = ~s3_q[acs_pkg::PIN_CS] & s2_q[acs_pkg::PIN_CS];
      rw_high = s2_q[acs_pkg::PIN_RW];
      rw_rise = ~s3_q[acs_pkg::PIN_RW] & s2_q[acs_pkg::PIN_RW];
      rw_fall = s3_q[acs_pkg::PIN_RW] & ~s2_q[acs_pkg::PIN_RW];
      sclk_rise = ~s3_q[acs_pkg::PIN_SCLK] & s2_q[acs_pkg::PIN_SCLK];
      sclk_fall = s3_q[acs_pkg::PIN_SCLK] & ~s2_q[acs_pkg::PIN_SCLK];
      din_s = s2_q[acs_pkg::PIN_DIN];
   end

   // Converter and serial port state.
   acs_conv_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d, lim_q, lim_d;
   logic busy_q, busy_d, hold_q, hold_d, pd_q, pd_d;
   logic temp_q, temp_d, otf_n_q, otf_n_d;
   logic [RW-1:0] sample_q, sample_d, result_q, result_d;
   logic [RW-1:0] osh_q, osh_d;
   logic dout_q, dout_d, oe_q, oe_d;
   logic [acs_pkg::FRAME_W-1:0] ish_q, ish_d;
   logic [acs_pkg::BITS_W-1:0] bits_q, bits_d;
   logic [acs_pkg::ADDR_W-1:0] addr_q, addr_d;
   logic [acs_pkg::THRESH_W-1:0] thr_q, thr_d;
   logic [RW-1:0] chan_val;
   logic otf_set, commit;
   logic [acs_pkg::ADDR_W-1:0] vin_idx;

   // The selected input as it would stand at the hold capacitor.
   always_comb begin
      vin_idx = addr_q - 8'h01;
      chan_val = '0;
      if (addr_q == acs_pkg::CH_TEMP) begin
         chan_val = temp_code;
      end else if (addr_q <= acs_pkg::ADDR_W'(acs_pkg::N_VIN)) begin
         chan_val = analog_inputs[vin_idx*RW +: RW];
      end
   end

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      lim_d = lim_q;
      busy_d = busy_q;
      hold_d = hold_q;
      pd_d = pd_q;
      temp_d = temp_q;
      sample_d = sample_q;
      result_d = result_q;
      otf_set = 1'b0;
      case (state_q)
         CV_IDLE: begin
            if (conv_rise) begin
               pd_d = 1'b0;
            end
            if (conv_fall) begin
               state_d = CV_RUN;
               busy_d = 1'b1;
               hold_d = 1'b1;
               pd_d = 1'b0;
               cnt_d = '0;
               sample_d = chan_val;
               temp_d = (addr_q == acs_pkg::CH_TEMP);
               if (addr_q == acs_pkg::CH_TEMP) begin
                  lim_d = CW'(CONV_T_CYC - 1);
               end else begin
                  lim_d = CW'(CONV_V_CYC - 1);
               end
            end
         end
         CV_RUN: begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == lim_q) begin
               state_d = CV_IDLE;
               busy_d = 1'b0;
               hold_d = 1'b0;
               result_d = sample_q;
               pd_d = conv_low;
               otf_set = temp_q &&
                  (sample_q[RW-1 -: acs_pkg::THRESH_W] > thr_q);
            end
         end
         default: begin
            state_d = CV_IDLE;
            busy_d = 1'b0;
            hold_d = 1'b0;
         end
      endcase
   end

   // Serial port, write capture, read shifting and the flag release.
   always_comb begin
      osh_d = osh_q;
      dout_d = dout_q;
      oe_d = oe_q;
      ish_d = ish_q;
      bits_d = bits_q;
      addr_d = addr_q;
      thr_d = thr_q;
      otf_n_d = otf_n_q;
      commit = cs_rise | (cs_low & rw_rise);
      if (commit) begin
         if (bits_q == acs_pkg::FRAME_SHORT) begin
            addr_d = ish_q[acs_pkg::ADDR_W-1:0];
         end else if (bits_q == acs_pkg::FRAME_LONG) begin
            addr_d = ish_q[acs_pkg::FRAME_W-1 -: acs_pkg::ADDR_W];
            if (ish_q[acs_pkg::FRAME_W-1 -: acs_pkg::ADDR_W] ==
                acs_pkg::SEL_THRESH) begin
               thr_d = ish_q[acs_pkg::THRESH_W-1:0];
            end
         end
         bits_d = '0;
      end
      if (cs_fall) begin
         bits_d = '0;
      end
      if (cs_low && !rw_high && sclk_rise) begin
         ish_d = {ish_q[acs_pkg::FRAME_W-2:0], din_s};
         if (bits_q != acs_pkg::FRAME_LONG) begin
            bits_d = bits_q + 1'b1;
         end
      end
      if (cs_low && rw_rise) begin
         osh_d = result_q;
         dout_d = result_q[RW-1];
         oe_d = 1'b1;
         otf_n_d = 1'b1;
      end else if (cs_low && rw_high && oe_q && sclk_fall) begin
         osh_d = {osh_q[RW-2:0], 1'b0};
         dout_d = osh_q[RW-2];
      end
      if (rw_fall || cs_rise) begin
         oe_d = 1'b0;
      end
      if (otf_set) begin
         otf_n_d = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= CV_IDLE;
         cnt_q <= '0;
         lim_q <= '0;
         busy_q <= 1'b0;
         hold_q <= 1'b0;
         pd_q <= 1'b0;
         temp_q <= 1'b0;
         sample_q <= '0;
         result_q <= '0;
         osh_q <= '0;
         dout_q <= 1'b0;
         oe_q <= 1'b0;
         ish_q <= '0;
         bits_q <= '0;
         addr_q <= acs_pkg::ADDR_RST;
         thr_q <= acs_pkg::THRESH_RST;
         otf_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         lim_q <= lim_d;
         busy_q <= busy_d;
         hold_q <= hold_d;
         pd_q <= pd_d;
         temp_q <= temp_d;
         sample_q <= sample_d;
         result_q <= result_d;
         osh_q <= osh_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
         ish_q <= ish_d;
         bits_q <= bits_d;
         addr_q <= addr_d;
         thr_q <= thr_d;
         otf_n_q <= otf_n_d;
      end
   end

   assign link.busy = busy_q;
   assign link.over_temp_flag_n = otf_n_q;
   assign link.dout = dout_q;
   assign link.dout_oe = oe_q;
   assign track_hold = hold_q;
   assign power_down = pd_q;
   assign result = result_q;
endmodule
`default_nettype wire

// ===== src/acs_host.sv
`timescale 1ns/10ps
`default_nettype none
module acs_host #(
   parameter int unsigned SCLK_HALF_CYC = acs_pkg::SCLK_HALF_CYC,
   parameter int unsigned START_LOW_CYC = acs_pkg::START_LOW_CYC
) (
   // Link to the device.
   acs_if.host link,
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Requests.
   input wire logic start_conv,
   input wire logic stay_low,
   input wire logic wr_req,
   input wire logic wr_long,
   input wire logic [acs_pkg::FRAME_W-1:0] wr_data,
   input wire logic rd_req,
   // Answers.
   output logic ready,
   output logic [acs_pkg::RESULT_W-1:0] rd_data,
   output logic rd_valid,
   output logic conv_done,
   output logic over_temp
);
   localparam int unsigned RW = acs_pkg::RESULT_W;
   localparam int unsigned TW = acs_pkg::TMR_W;

   initial begin
      if (SCLK_HALF_CYC < acs_pkg::SCLK_MIN_CYC ||
          SCLK_HALF_CYC >= (1 << TW) ||
          START_LOW_CYC < 1 || START_LOW_CYC >= (1 << TW)) begin
         $error("acs_host: timing parameter out of range");
      end
   end

   typedef enum logic [3:0] {H_IDLE, H_WAKE, H_CONV, H_SETUP, H_WLOW,
      H_WHIGH, H_RLOW, H_RHIGH, H_END, H_GAP} acs_hstate_t;

   logic [acs_pkg::N_HOST_PINS-1:0] s1_q, s2_q, s3_q, pins;
   assign pins[acs_pkg::HPIN_BUSY] = link.busy;
   assign pins[acs_pkg::HPIN_OTF] = link.over_temp_flag_n;
   assign pins[acs_pkg::HPIN_DOUT] = link.dout_bus;

   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= 3'h6;
         s2_q <= 3'h6;
         s3_q <= 3'h6;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   acs_hstate_t st_q, st_d;
   logic [TW-1:0] tmr_q, tmr_d;
   logic [acs_pkg::FRAME_W-1:0] sh_q, sh_d;
   logic [acs_pkg::BITS_W-1:0] n_q, n_d;
   logic [RW-1:0] rsh_q, rsh_d, rdat_q, rdat_d;
   logic rd_q, rd_d, rv_q, rv_d, done_q, done_d, ot_q, ot_d, rdy_q, rdy_d;
   logic cv_q, cv_d, cs_q, cs_d, rwp_q, rwp_d, sck_q, sck_d, din_q, din_d;
   logic tdone;

   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      sh_d = sh_q;
      n_d = n_q;
      rsh_d = rsh_q;
      rdat_d = rdat_q;
      rd_d = rd_q;
      cv_d = cv_q;
      cs_d = cs_q;
      rwp_d = rwp_q;
      sck_d = sck_q;
      din_d = din_q;
      rv_d = 1'b0;
      tdone = (tmr_q == '0);
      if (!tdone) begin
         tmr_d = tmr_q - 1'b1;
      end
      done_d = s3_q[acs_pkg::HPIN_BUSY] & ~s2_q[acs_pkg::HPIN_BUSY];
      ot_d = ~s2_q[acs_pkg::HPIN_OTF];
      case (st_q)
         H_IDLE: begin
            if (start_conv) begin
               st_d = cv_q ? H_CONV : H_WAKE;
               cv_d = ~cv_q;
               tmr_d = TW'(START_LOW_CYC - 1);
            end else if (wr_req || rd_req) begin
               cs_d = 1'b0;
               rd_d = ~wr_req;
               sh_d = wr_long ? wr_data : {wr_data[7:0], 8'h00};
               n_d = wr_long ? acs_pkg::FRAME_LONG : acs_pkg::FRAME_SHORT;
               tmr_d = TW'(SCLK_HALF_CYC - 1);
               st_d = H_SETUP;
            end
         end
         H_WAKE: if (tdone) begin
            cv_d = 1'b0;
            tmr_d = TW'(START_LOW_CYC - 1);
            st_d = H_CONV;
         end
         H_CONV: if (tdone) begin
            cv_d = ~stay_low;
            st_d = H_IDLE;
         end
         H_SETUP: if (tdone) begin
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            if (rd_q) begin
               rwp_d = 1'b1;
               n_d = acs_pkg::BITS_W'(RW);
               st_d = H_RHIGH;
            end else begin
               sck_d = 1'b0;
               din_d = sh_q[acs_pkg::FRAME_W-1];
               sh_d = {sh_q[acs_pkg::FRAME_W-2:0], 1'b0};
               st_d = H_WLOW;
            end
         end
         H_WLOW: if (tdone) begin
            sck_d = 1'b1;
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            st_d = H_WHIGH;
         end
         H_WHIGH: if (tdone) begin
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            n_d = n_q - 1'b1;
            if (n_q == 5'h01) begin
               st_d = H_END;
            end else begin
               sck_d = 1'b0;
               din_d = sh_q[acs_pkg::FRAME_W-1];
               sh_d = {sh_q[acs_pkg::FRAME_W-2:0], 1'b0};
               st_d = H_WLOW;
            end
         end
         H_RHIGH: if (tdone) begin
            rsh_d = {rsh_q[RW-2:0], s2_q[acs_pkg::HPIN_DOUT]};
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            n_d = n_q - 1'b1;
            if (n_q == 5'h01) begin
               rdat_d = {rsh_q[RW-2:0], s2_q[acs_pkg::HPIN_DOUT]};
               rwp_d = 1'b0;
               st_d = H_END;
            end else begin
               sck_d = 1'b0;
               st_d = H_RLOW;
            end
         end
         H_RLOW: if (tdone) begin
            sck_d = 1'b1;
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            st_d = H_RHIGH;
         end
         H_END: if (tdone) begin
            cs_d = 1'b1;
            tmr_d = TW'(SCLK_HALF_CYC - 1);
            st_d = H_GAP;
         end
         H_GAP: if (tdone) begin
            rv_d = rd_q;
            st_d = H_IDLE;
         end
         default: st_d = H_IDLE;
      endcase
      rdy_d = (st_d == H_IDLE);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st_q <= H_IDLE;
         tmr_q <= '0;
         sh_q <= '0;
         n_q <= '0;
         rsh_q <= '0;
         rdat_q <= '0;
         rd_q <= 1'b0;
         rv_q <= 1'b0;
         done_q <= 1'b0;
         ot_q <= 1'b0;
         rdy_q <= 1'b0;
         cv_q <= 1'b1;
         cs_q <= 1'b1;
         rwp_q <= 1'b0;
         sck_q <= 1'b1;
         din_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         sh_q <= sh_d;
         n_q <= n_d;
         rsh_q <= rsh_d;
         rdat_q <= rdat_d;
         rd_q <= rd_d;
         rv_q <= rv_d;
         done_q <= done_d;
         ot_q <= ot_d;
         rdy_q <= rdy_d;
         cv_q <= cv_d;
         cs_q <= cs_d;
         rwp_q <= rwp_d;
         sck_q <= sck_d;
         din_q <= din_d;
      end
   end

   assign link.convert_start_n = cv_q;
   assign link.cs_n = cs_q;
   assign link.rd_wr = rwp_q;
   assign link.sclk = sck_q;
   assign link.din = din_q;
   assign ready = rdy_q;
   assign rd_data = rdat_q;
   assign rd_valid = rv_q;
   assign conv_done = done_q;
   assign over_temp = ot_q;
endmodule
`default_nettype wire

// ===== tb/acs_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module acs_assertions #(
   parameter int unsigned CONV_V_CYC = 20,
   parameter int unsigned CONV_T_CYC = 60
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Link signals.
   input wire logic convert_start_n,
   input wire logic busy,
   input wire logic over_temp_flag_n,
   input wire logic cs_n,
   input wire logic rd_wr,
   input wire logic sclk,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;

   // Counts consecutive busy cycles so the conversion length can be judged.
   always_comb begin
      cnt_d = reset ? 16'h0000 : (busy ? cnt_q + 16'h0001 : 16'h0000);
   end
   always_ff @(posedge clk) begin
      cnt_q <= cnt_d;
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_start;
      $fell(convert_start_n) ##0 !busy;
   endsequence
   sequence s_deselected;
      cs_n [*4];
   endsequence
   sequence s_read_open;
      $rose(rd_wr) ##0 !cs_n;
   endsequence

   property p_start_busy;
      s_start |-> ##[1:5] busy;
   endproperty
   property p_busy_len;
      $fell(busy) |-> (cnt_q == 16'(CONV_V_CYC)) ||
         (cnt_q == 16'(CONV_T_CYC));
   endproperty
   property p_busy_max;
      cnt_q <= 16'(CONV_T_CYC);
   endproperty
   property p_busy_min;
      $rose(busy) |-> busy [*8];
   endproperty
   property p_flag_cause;
      $fell(over_temp_flag_n) |-> $fell(busy);
   endproperty
   property p_flag_clear;
      s_read_open |-> ##[1:5] (over_temp_flag_n || $fell(busy));
   endproperty
   property p_oe_cause;
      $rose(dout_oe) |-> !cs_n && rd_wr;
   endproperty
   property p_oe_release;
      dout_oe && (cs_n || !rd_wr) |-> ##[0:5] !dout_oe;
   endproperty
   property p_write_quiet;
      s_deselected |-> !dout_oe;
   endproperty
   property p_dout_shift;
      dout_oe && $past(dout_oe) && $changed(dout) |-> !sclk;
   endproperty

   a_start_busy: assert property (p_start_busy)
      else $error("busy did not follow a convert start");
   a_busy_len: assert property (p_busy_len)
      else $error("busy length matches no channel");
   a_busy_max: assert property (p_busy_max)
      else $error("busy held past the longest conversion");
   a_busy_min: assert property (p_busy_min)
      else $error("busy dropped too early");
   a_flag_cause: assert property (p_flag_cause)
      else $error("flag fell outside a conversion end");
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not released by a read");
   a_oe_cause: assert property (p_oe_cause)
      else $error("data out driven without a selected read");
   a_oe_release: assert property (p_oe_release)
      else $error("data out not released");
   a_write_quiet: assert property (p_write_quiet)
      else $error("data out driven while deselected");
   a_dout_shift: assert property (p_dout_shift)
      else $error("data out changed with serial clock high");
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH %0t %s", $time, msg); \
   end \
end
module tb_top;
   localparam int unsigned V_CYC = 20;
   localparam int unsigned T_CYC = 60;
   typedef struct {
      logic [7:0] ch;
      logic [7:0] thr;
      logic [9:0] exp;
      logic ot;
   } acs_row_t;
   acs_row_t rows [6] = '{'{8'h00, 8'hB1, 10'h2C8, 1'b1},
      '{8'h00, 8'hB2, 10'h2C8, 1'b0}, '{8'h01, 8'hFF, 10'h155, 1'b0},
      '{8'h02, 8'h00, 10'h2AA, 1'b0}, '{8'h03, 8'h10, 10'h3FF, 1'b0},
      '{8'h04, 8'hB1, 10'h001, 1'b0}};
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic start_conv = 1'b0;
   logic stay_low = 1'b0;
   logic wr_req = 1'b0;
   logic wr_long = 1'b0;
   logic [15:0] wr_data = 16'h0000;
   logic rd_req = 1'b0;
   logic [39:0] analog_inputs = {10'h001, 10'h3FF, 10'h2AA, 10'h155};
   logic [9:0] temp_code = 10'h2C8;
   logic ready, rd_valid, conv_done, over_temp, track_hold, power_down;
   logic [9:0] rd_data, result;
   int bad_count = 0;
   int check_count = 0;
   int cycles = 0;
   int busy_len = 0;
   int last_len = 0;

   acs_if link();
   acs_device #(.CONV_V_CYC(V_CYC), .CONV_T_CYC(T_CYC)) i_acs_device (
      .link(link.dev), .clk(clk), .reset(reset),
      .analog_inputs(analog_inputs), .temp_code(temp_code),
      .track_hold(track_hold), .power_down(power_down), .result(result));
   acs_host i_acs_host (
      .link(link.host), .clk(clk), .reset(reset),
      .start_conv(start_conv), .stay_low(stay_low), .wr_req(wr_req),
      .wr_long(wr_long), .wr_data(wr_data), .rd_req(rd_req),
      .ready(ready), .rd_data(rd_data), .rd_valid(rd_valid),
      .conv_done(conv_done), .over_temp(over_temp));
   acs_assertions #(.CONV_V_CYC(V_CYC), .CONV_T_CYC(T_CYC))
      i_acs_assertions (
      .clk(clk), .reset(reset), .convert_start_n(link.convert_start_n),
      .busy(link.busy), .over_temp_flag_n(link.over_temp_flag_n),
      .cs_n(link.cs_n), .rd_wr(link.rd_wr), .sclk(link.sclk),
      .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe));

   always #2.5 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Measures each busy pulse and cuts a hung run short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      busy_len <= link.busy ? busy_len + 1 : 0;
      if (!link.busy && busy_len != 0) begin
         last_len <= busy_len;
      end
      if (cycles == 40000) begin
         bad_count++;
         end_sim();
      end
   end

   // Operation codes: 0 short write, 1 long write, 2 read, 3 convert.
   task automatic req(input int op, input logic [15:0] d);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (ready !== 1'b1 && n < 5000);
      wr_data = d;
      wr_long = (op == 1);
      wr_req = (op < 2);
      rd_req = (op == 2);
      start_conv = (op == 3);
      @(posedge clk);
      #1;
      {start_conv, wr_req, rd_req} = 3'h0;
   endtask

   task automatic wait_pulse(input bit rd);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (((rd ? rd_valid : conv_done) !== 1'b1) && n < 5000);
      `CHK(n < 5000, 1'b1, "no completion")
   endtask

   task automatic convert();
      req(3, 16'h0000);
      repeat (10) @(posedge clk);
      #1;
      `CHK(track_hold, 1'b1, "not holding")
      wait_pulse(0);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      #1;
      reset = 1'b0;
      foreach (rows[i]) begin
         req(1, {8'h0F, rows[i].thr});
         req(0, {8'h00, rows[i].ch});
         convert();
         `CHK(result, rows[i].exp, "result")
         `CHK(last_len, (rows[i].ch == 8'h00) ? T_CYC : V_CYC,
            "busy length")
         `CHK(track_hold, 1'b0, "still holding")
         `CHK(link.over_temp_flag_n, !rows[i].ot, "flag")
         `CHK(over_temp, rows[i].ot, "host flag")
         req(2, 16'h0000);
         wait_pulse(1);
         `CHK(rd_data, rows[i].exp, "read data")
         `CHK(link.over_temp_flag_n, 1'b1, "flag after read")
         `CHK(over_temp, 1'b0, "host flag after read")
         `CHK(link.dout_oe, 1'b0, "data out left on")
      end
      stay_low = 1'b1;
      convert();
      `CHK(power_down, 1'b1, "no power down")
      stay_low = 1'b0;
      convert();
      `CHK(power_down, 1'b0, "stuck in power down")
      req(1, 16'h02FF);
      convert();
      `CHK(result, 10'h2AA, "address from long frame")
      req(0, 16'h0000);
      convert();
      `CHK(link.over_temp_flag_n, 1'b0, "threshold overwritten")
      req(3, 16'h0000);
      repeat (10) @(posedge clk);
      #1;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      reset = 1'b0;
      `CHK(link.busy, 1'b0, "busy after reset")
      `CHK(link.over_temp_flag_n, 1'b1, "flag after reset")
      `CHK(track_hold, 1'b0, "hold after reset")
      convert();
      `CHK(result, 10'h2C8, "address reset")
      `CHK(link.over_temp_flag_n, 1'b1, "threshold reset")
      end_sim();
   end
endmodule
`undef CHK
`default_nettype wire
